// ### logic/txtpm_pkg.sv
package txtpm_pkg;
   localparam int TXTPM_BYTE_W = 8;
   localparam int TXTPM_CRC_W = 16;
   localparam int TXTPM_DAC_W = 16;
   localparam int TXTPM_MODE_W = 2;
   localparam int TXTPM_QUEUE_DEPTH = 128;

   // Transmit mode field codes of modem_control_1
   localparam logic [TXTPM_MODE_W-1:0] TXTPM_MODE_NORMAL = 2'h0;
   localparam logic [TXTPM_MODE_W-1:0] TXTPM_MODE_LOOP = 2'h2;
   localparam logic [TXTPM_MODE_W-1:0] TXTPM_MODE_PRBS = 2'h3;

   // Pattern generator seed and the byte clocked in per step
   localparam logic [TXTPM_CRC_W-1:0] TXTPM_CRC_SEED = 16'h0000;
   localparam logic [TXTPM_CRC_W-1:0] TXTPM_CRC_POLY_REFL = 16'h8408;
   localparam logic [TXTPM_BYTE_W-1:0] TXTPM_PRBS_FEED = 8'hff;

   // Synchronisation header
   localparam int TXTPM_PREAMBLE_LEN = 4;
   localparam logic [TXTPM_BYTE_W-1:0] TXTPM_PREAMBLE_BYTE = 8'h00;
   localparam logic [TXTPM_BYTE_W-1:0] TXTPM_SFD_BYTE = 8'ha7;

   // Value that puts a carrier on the DACs
   localparam logic [TXTPM_DAC_W-1:0] TXTPM_DAC_CARRIER = 16'h1800;
   localparam logic [TXTPM_DAC_W-1:0] TXTPM_DAC_OFF = 16'h0000;

   typedef enum logic [1:0] {
      TXTPM_IDLE,
      TXTPM_PREAMBLE,
      TXTPM_SFD,
      TXTPM_PAYLOAD
   } txtpm_state_t;

   typedef struct packed {
      logic valid;
      logic [TXTPM_BYTE_W-1:0] data;
   } txtpm_stream_t;

   typedef struct packed {
      logic enable;
      logic [TXTPM_DAC_W-1:0] value;
   } txtpm_dac_t;
endpackage

// ### logic/txtpm_crc.sv
`timescale 1ns/1ps
`default_nettype none
module txtpm_crc
   import txtpm_pkg::*;
#(
   parameter int CRC_W = TXTPM_CRC_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic step,
   output logic [CRC_W-1:0] crc
);
   logic [CRC_W-1:0] crc_r;
   logic [CRC_W-1:0] crc_nxt;
   logic [CRC_W-1:0] acc;

   // Byte-wide, LSB first: one step folds in a whole 0xff byte
   always_comb begin
      acc = crc_r ^ {{(CRC_W-TXTPM_BYTE_W){1'b0}}, TXTPM_PRBS_FEED};
      for (int i = 0; i < TXTPM_BYTE_W; i++) begin
         if (acc[0]) begin
            acc = (acc >> 1) ^ TXTPM_CRC_POLY_REFL;
         end else begin
            acc = acc >> 1;
         end
      end
      crc_nxt = crc_r;
      if (clear) begin
         crc_nxt = TXTPM_CRC_SEED;
      end else if (step) begin
         crc_nxt = acc;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         crc_r <= TXTPM_CRC_SEED;
      end else begin
         crc_r <= crc_nxt;
      end
   end

   assign crc = crc_r;
endmodule
`default_nettype wire

// ### logic/txtpm_top.sv
// Overview of operation
// - In carrier operation the transmitter is on while the DAC inputs are held at a static value.
// - Mode 3 plus transmit-on sends a pseudorandom stream from the CRC generator instead of queue data.
// - Each pseudorandom byte is the CRC low byte, after which the CRC absorbs the byte 0xff.
// - The pseudorandom sequence runs 32767 bytes before it repeats.
// - The payload starts 0x00, 0x78, 0xb8, 0x4b, 0x99, 0xc3, 0xe9 and follows the CRC iteration.
// - Every transmit mode sends preamble and start-of-frame delimiter ahead of the payload.
// - Mode 2 replays the 128-byte transmit queue endlessly and ignores underflow.
`timescale 1ns/1ps
`default_nettype none
module txtpm_top
   import txtpm_pkg::*;
#(
   parameter int QUEUE_DEPTH = TXTPM_QUEUE_DEPTH,
   parameter int PREAMBLE_LEN = TXTPM_PREAMBLE_LEN
) (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic [TXTPM_MODE_W-1:0] TX_MODE,
   input wire logic [TXTPM_DAC_W-1:0] DAC_OVERRIDE,
   input wire logic OSC_ON_STROBE,
   input wire logic OSC_STABLE,
   input wire logic TX_ON_STROBE,
   input wire logic TX_OFF_STROBE,
   input wire logic QUEUE_WR,
   input wire logic [TXTPM_BYTE_W-1:0] QUEUE_DATA,
   input wire logic OUT_READY,
   output logic OSC_RUNNING,
   output logic TX_ENABLE,
   output txtpm_stream_t OUT,
   output txtpm_dac_t DAC,
   output logic UNDERFLOW,
   output logic QUEUE_FULL
);
   localparam int PTR_W = $clog2(QUEUE_DEPTH);
   localparam int CNT_W = PTR_W + 1;
   localparam int PRE_W = $clog2(PREAMBLE_LEN + 1);
   localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(QUEUE_DEPTH);
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PREAMBLE_LEN - 1);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(QUEUE_DEPTH - 1);

   logic [TXTPM_BYTE_W-1:0] queue_mem [QUEUE_DEPTH];

   txtpm_state_t state_r, state_nxt;
   logic [PRE_W-1:0] pre_cnt_r, pre_cnt_nxt;
   logic [PTR_W-1:0] wr_ptr_r, wr_ptr_nxt;
   logic [PTR_W-1:0] rd_ptr_r, rd_ptr_nxt;
   logic [CNT_W-1:0] count_r, count_nxt;
   logic osc_r, osc_nxt;
   logic tx_en_r, tx_en_nxt;
   logic underflow_r, underflow_nxt;
   logic full_r, full_nxt;
   txtpm_stream_t out_r, out_nxt;
   txtpm_dac_t dac_r, dac_nxt;

   logic load;
   logic wr_ok;
   logic rd_take;
   logic test_mode;
   logic crc_clear;
   logic crc_step;
   logic [TXTPM_CRC_W-1:0] crc;

   txtpm_crc #(
      .CRC_W(TXTPM_CRC_W)
   ) u_crc (
      .clk(CLOCK),
      .rst_n(RST_N),
      .clear(crc_clear),
      .step(crc_step),
      .crc(crc)
   );

   assign test_mode = (TX_MODE == TXTPM_MODE_LOOP) || (TX_MODE == TXTPM_MODE_PRBS);
   // A new byte may be staged when the output slot is empty or being taken
   assign load = !out_r.valid || OUT_READY;
   assign wr_ok = QUEUE_WR && (count_r != DEPTH_C);

   always_comb begin
      state_nxt = state_r;
      pre_cnt_nxt = pre_cnt_r;
      rd_ptr_nxt = rd_ptr_r;
      out_nxt = out_r;
      osc_nxt = osc_r;
      underflow_nxt = 1'b0;
      crc_clear = 1'b0;
      crc_step = 1'b0;
      rd_take = 1'b0;
      if (OUT_READY) begin
         out_nxt.valid = 1'b0;
      end
      if (OSC_ON_STROBE) begin
         osc_nxt = 1'b1;
      end
      case (state_r)
         TXTPM_IDLE: begin
            // strobe gate: transmit-on is ignored until the oscillator is up
            if (TX_ON_STROBE && osc_r && OSC_STABLE) begin
               state_nxt = TXTPM_PREAMBLE;
               pre_cnt_nxt = '0;
               // fresh seed: each burst restarts the sequence at 0x00
               crc_clear = 1'b1;
            end
         end
         TXTPM_PREAMBLE: begin
            if (load) begin
               out_nxt.valid = 1'b1;
               out_nxt.data = TXTPM_PREAMBLE_BYTE;
               pre_cnt_nxt = pre_cnt_r + PRE_W'(1);
               if (pre_cnt_r == PRE_LAST) begin
                  state_nxt = TXTPM_SFD;
               end
            end
         end
         TXTPM_SFD: begin
            if (load) begin
               out_nxt.valid = 1'b1;
               out_nxt.data = TXTPM_SFD_BYTE;
               state_nxt = TXTPM_PAYLOAD;
            end
         end
         TXTPM_PAYLOAD: begin
            if (load) begin
               case (TX_MODE)
                  TXTPM_MODE_PRBS: begin
                     // CRC low byte out, then step with 0xff
                     out_nxt.valid = 1'b1;
                     out_nxt.data = crc[TXTPM_BYTE_W-1:0];
                     crc_step = 1'b1;
                  end
                  TXTPM_MODE_LOOP: begin
                     out_nxt.valid = 1'b1;
                     out_nxt.data = queue_mem[rd_ptr_r];
                     rd_ptr_nxt = (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + PTR_W'(1);
                  end
                  default: begin
                     // normal packet path: empty queue ends the frame
                     if (count_r == '0) begin
                        underflow_nxt = 1'b1;
                        state_nxt = TXTPM_IDLE;
                     end else begin
                        out_nxt.valid = 1'b1;
                        out_nxt.data = queue_mem[rd_ptr_r];
                        rd_ptr_nxt = (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + PTR_W'(1);
                        rd_take = 1'b1;
                     end
                  end
               endcase
            end
         end
         default: begin
            state_nxt = TXTPM_IDLE;
         end
      endcase
      // Test modes run forever, so an explicit stop is needed
      if (TX_OFF_STROBE && state_r != TXTPM_IDLE) begin
         state_nxt = TXTPM_IDLE;
         out_nxt.valid = 1'b0;
         rd_take = 1'b0;
         rd_ptr_nxt = rd_ptr_r;
      end
   end

   always_comb begin
      wr_ptr_nxt = wr_ok ? ((wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + PTR_W'(1)) : wr_ptr_r;
      count_nxt = count_r;
      if (wr_ok && !rd_take) begin
         count_nxt = count_r + CNT_W'(1);
      end else if (!wr_ok && rd_take) begin
         count_nxt = count_r - CNT_W'(1);
      end
      full_nxt = (count_nxt == DEPTH_C);
      tx_en_nxt = (state_nxt != TXTPM_IDLE);
      dac_nxt.enable = 1'b0;
      dac_nxt.value = TXTPM_DAC_OFF;
      // static DAC only while transmitting in a test mode
      if (tx_en_nxt && test_mode && DAC_OVERRIDE != TXTPM_DAC_OFF) begin
         dac_nxt.enable = 1'b1;
         dac_nxt.value = DAC_OVERRIDE;
      end
   end

   // Memory kept out of reset so it maps onto plain RAM
   always_ff @(posedge CLOCK) begin
      if (wr_ok) begin
         queue_mem[wr_ptr_r] <= QUEUE_DATA;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         state_r <= TXTPM_IDLE;
         pre_cnt_r <= '0;
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
         osc_r <= 1'b0;
         tx_en_r <= 1'b0;
         underflow_r <= 1'b0;
         full_r <= 1'b0;
         out_r <= '0;
         dac_r <= '0;
      end else begin
         state_r <= state_nxt;
         pre_cnt_r <= pre_cnt_nxt;
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r <= count_nxt;
         osc_r <= osc_nxt;
         tx_en_r <= tx_en_nxt;
         underflow_r <= underflow_nxt;
         full_r <= full_nxt;
         out_r <= out_nxt;
         dac_r <= dac_nxt;
      end
   end

   assign OSC_RUNNING = osc_r;
   assign TX_ENABLE = tx_en_r;
   assign OUT = out_r;
   assign DAC = dac_r;
   assign UNDERFLOW = underflow_r;
   assign QUEUE_FULL = full_r;
endmodule
`default_nettype wire

// ### tb/txtpm_checker.sv
`timescale 1ns/1ps
`default_nettype none
module txtpm_checker
   import txtpm_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic [TXTPM_MODE_W-1:0] TX_MODE,
   input wire logic [TXTPM_DAC_W-1:0] DAC_OVERRIDE,
   input wire logic OSC_ON_STROBE,
   input wire logic OSC_STABLE,
   input wire logic TX_ON_STROBE,
   input wire logic TX_OFF_STROBE,
   input wire logic OUT_READY,
   input wire logic OSC_RUNNING,
   input wire logic TX_ENABLE,
   input wire txtpm_stream_t OUT,
   input wire txtpm_dac_t DAC,
   input wire logic UNDERFLOW
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_N);
   osc_start_a: assert property (OSC_ON_STROBE |=> OSC_RUNNING) else $error("osc not running");
   // First preamble byte is staged one cycle after the enable rises
   tx_start_a: assert property ((TX_ON_STROBE && !TX_ENABLE && OSC_RUNNING && OSC_STABLE)
      ##1 !TX_OFF_STROBE |-> TX_ENABLE ##1 OUT.valid && OUT.data == TXTPM_PREAMBLE_BYTE)
      else $error("no frame start");
   sfd_order_a: assert property ($rose(TX_ENABLE) ##1 (OUT_READY && OUT.valid && !TX_OFF_STROBE)[*4]
      |=> OUT.valid && OUT.data == TXTPM_SFD_BYTE) else $error("delimiter misplaced");
   byte_hold_a: assert property (OUT.valid && !OUT_READY && !TX_OFF_STROBE |=> $stable(OUT))
      else $error("byte changed while stalled");
   dac_carrier_a: assert property (DAC.enable |-> TX_ENABLE && $past(TX_MODE[1])
      && DAC.value == $past(DAC_OVERRIDE) && DAC.value != 16'h0000) else $error("bad override");
   dac_idle_a: assert property (!TX_ENABLE |-> DAC == '0) else $error("override while idle");
   test_stop_a: assert property (TX_OFF_STROBE && TX_ENABLE && TX_MODE[1]
      |=> !TX_ENABLE && !OUT.valid) else $error("test mode did not stop");
   underflow_end_a: assert property (UNDERFLOW |-> !TX_ENABLE && !OUT.valid && !$past(TX_MODE[1]))
      else $error("bad underflow");
   cover property ($rose(DAC.enable));
   cover property (UNDERFLOW);
   cover property (TX_ENABLE && TX_MODE == TXTPM_MODE_LOOP);
endmodule
`default_nettype wire

// ### tb/txtpm_host.sv
`timescale 1ns/1ps
`default_nettype none
module txtpm_host (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic osc_on,
   input wire logic slow,
   output logic osc_stable,
   output logic out_ready
);
   logic [4:0] settle_r;
   assign osc_stable = settle_r == 5'h1f;
   // Slow pacing stalls the stream every other cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         settle_r <= 5'h00;
         out_ready <= 1'b0;
      end else begin
         if ((osc_on || settle_r != 5'h00) && settle_r != 5'h1f)
            settle_r <= settle_r + 5'h01;
         out_ready <= slow ? ~out_ready : 1'b1;
      end
   end
endmodule
`default_nettype wire

// ### tb/txtpm_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module txtpm_top_test;
   import txtpm_pkg::*;
   logic clock = 1'b0, rst_n = 1'b0, osc_on = 1'b0, tx_on = 1'b0, tx_off = 1'b0, q_wr = 1'b0, slow = 1'b0;
   logic [1:0] mode = 2'h0;
   logic [15:0] dac_ov = 16'h0000;
   logic [7:0] q_data = 8'h00;
   logic osc_running, tx_en, underflow, q_full, osc_stable, out_ready;
   txtpm_stream_t out_s;
   txtpm_dac_t dac_s;
   int errors = 0;
   int check_count = 0;
   localparam logic [7:0] PRBS [7] = '{8'h00, 8'h78, 8'hb8, 8'h4b, 8'h99, 8'hc3, 8'he9};
   always #4 clock = ~clock;
   txtpm_top dut (.CLOCK(clock), .RST_N(rst_n), .TX_MODE(mode), .DAC_OVERRIDE(dac_ov),
      .OSC_ON_STROBE(osc_on), .OSC_STABLE(osc_stable), .TX_ON_STROBE(tx_on), .TX_OFF_STROBE(tx_off),
      .QUEUE_WR(q_wr), .QUEUE_DATA(q_data), .OUT_READY(out_ready), .OSC_RUNNING(osc_running),
      .TX_ENABLE(tx_en), .OUT(out_s), .DAC(dac_s), .UNDERFLOW(underflow), .QUEUE_FULL(q_full));
   txtpm_host host (.clk(clock), .rst_n(rst_n), .osc_on(osc_on), .slow(slow), .osc_stable(osc_stable),
      .out_ready(out_ready));
   task automatic tally_and_finish;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic get_byte(output logic [7:0] b);
      int n;
      for (n = 0; n < 60 && !(out_s.valid === 1'b1 && out_ready === 1'b1); n++)
         @(negedge clock);
      if (n == 60) begin
         b = 8'h00;
         chk("stream wait", 17'h0, 17'h1);
         tally_and_finish();
      end else begin
         b = out_s.data;
         @(negedge clock);
      end
   endtask
   task automatic pulse_tx(input logic on);
      @(negedge clock);
      if (on) tx_on = 1'b1; else tx_off = 1'b1;
      @(negedge clock);
      tx_on = 1'b0;
      tx_off = 1'b0;
   endtask
   task automatic expect_hdr;
      logic [7:0] b;
      for (int i = 0; i <= TXTPM_PREAMBLE_LEN; i++) begin
         get_byte(b);
         chk("header", (i < TXTPM_PREAMBLE_LEN) ? {9'h0, TXTPM_PREAMBLE_BYTE} : {9'h0, TXTPM_SFD_BYTE}, b);
      end
   endtask
   task automatic t_osc;
      int n;
      pulse_tx(1'b1);
      repeat (3) @(negedge clock);
      chk("tx before osc", 17'h0, tx_en);
      osc_on = 1'b1;
      @(negedge clock);
      osc_on = 1'b0;
      chk("osc running", 17'h1, osc_running);
      for (n = 0; n < 64 && osc_stable !== 1'b1; n++)
         @(negedge clock);
      chk("osc stable", 17'h1, osc_stable);
      if (osc_stable !== 1'b1) begin
         tally_and_finish();
      end
   endtask
   task automatic t_normal;
      logic [7:0] b;
      @(negedge clock);
      q_wr = 1'b1;
      q_data = 8'h5a;
      @(negedge clock);
      q_wr = 1'b0;
      pulse_tx(1'b1);
      expect_hdr();
      get_byte(b);
      chk("payload", 17'h5a, b);
      chk("underflow", 17'h1, underflow);
      chk("tx end", 17'h0, tx_en);
   endtask
   task automatic t_prbs;
      logic [7:0] b;
      mode = TXTPM_MODE_PRBS;
      dac_ov = TXTPM_DAC_CARRIER;
      slow = 1'b1;
      pulse_tx(1'b1);
      expect_hdr();
      for (int i = 0; i < 7; i++) begin
         get_byte(b);
         chk("prbs", {9'h0, PRBS[i]}, b);
      end
      chk("dac carrier", {1'b1, TXTPM_DAC_CARRIER}, dac_s);
      pulse_tx(1'b0);
      chk("dac released", 17'h0, dac_s);
      slow = 1'b0;
   endtask
   task automatic t_resume;
      logic [7:0] b;
      mode = TXTPM_MODE_PRBS;
      dac_ov = TXTPM_DAC_CARRIER;
      pulse_tx(1'b1);
      expect_hdr();
      get_byte(b);
      chk("resume first", {9'h0, PRBS[0]}, b);
      // Back to normal mid-frame: the empty queue must end the frame
      mode = TXTPM_MODE_NORMAL;
      @(negedge clock);
      chk("resume underflow", 17'h1, underflow);
      chk("resume tx end", 17'h0, tx_en);
      chk("resume dac", 17'h0, dac_s);
   endtask
   task automatic t_loop;
      logic [7:0] b;
      mode = TXTPM_MODE_NORMAL;
      dac_ov = 16'h0000;
      for (int i = 0; i < 129; i++) begin
         @(negedge clock);
         q_wr = 1'b1;
         q_data = i[7:0];
      end
      @(negedge clock);
      q_wr = 1'b0;
      chk("queue full", 17'h1, q_full);
      mode = TXTPM_MODE_LOOP;
      pulse_tx(1'b1);
      expect_hdr();
      for (int k = 0; k < 130; k++) begin
         get_byte(b);
         chk("replay", 17'(k % 128), b);
         chk("no underflow", 17'h0, underflow);
      end
      chk("no carrier", 17'h0, dac_s);
      pulse_tx(1'b0);
      chk("loop stop", 17'h0, tx_en);
   endtask
   initial begin
      repeat (10) @(negedge clock);
      rst_n = 1'b1;
      t_osc();
      t_normal();
      t_prbs();
      t_resume();
      t_loop();
      tally_and_finish();
   end
endmodule
bind txtpm_top txtpm_checker chk_i (.CLOCK(CLOCK), .RST_N(RST_N), .TX_MODE(TX_MODE),
   .DAC_OVERRIDE(DAC_OVERRIDE), .OSC_ON_STROBE(OSC_ON_STROBE), .OSC_STABLE(OSC_STABLE),
   .TX_ON_STROBE(TX_ON_STROBE), .TX_OFF_STROBE(TX_OFF_STROBE), .OUT_READY(OUT_READY),
   .OSC_RUNNING(OSC_RUNNING), .TX_ENABLE(TX_ENABLE), .OUT(OUT), .DAC(DAC), .UNDERFLOW(UNDERFLOW));
`default_nettype wire
